//--- hw/spc_top.sv
// Sleep mode sequencing, peripheral clock gating and analog power control.
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module spc_top #(
    parameter logic [7:0] DEEP_WAKE_CYC = `SPC_DEEP_WAKE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_instr_i,
    input wire logic wake_irq_i,
    input wire logic conv_start_i,
    input wire logic [2:0] brownout_level_fuses_i,
    input wire logic debug_enable_fuse_i,
    input wire logic jtag_enable_fuse_i,
    input wire logic wdt_enable_i,
    input wire logic tap_shift_i,
    input wire logic tdo_data_i,
    input wire logic [7:0] wake_pin_mask_i,
    output logic cpu_clk_en_o,
    output logic flash_clk_en_o,
    output logic io_clk_en_o,
    output logic conv_clk_en_o,
    output logic osc_run_o,
    output logic lcd_clk_en_o,
    output logic tim16_clk_en_o,
    output logic spi_clk_en_o,
    output logic usart_clk_en_o,
    output logic conv_en_o,
    output logic conv_extended_o,
    output logic cmp_en_o,
    output logic cmp_mux_ok_o,
    output logic vref_en_o,
    output logic bod_en_o,
    output logic wdt_en_o,
    output logic jtag_en_o,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic cpu_halt_o,
    output logic [7:0] port_buf_en_o,
    output logic [7:0] conv_buf_en_o,
    output logic [1:0] cmp_buf_en_o,
    output logic [4:0] reg_block_o
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    function automatic logic mode_valid(input logic [2:0] m);
        return (m == spc_pkg::SPC_MODE_IDLE) || (m == spc_pkg::SPC_MODE_NOISE) ||
               (m == spc_pkg::SPC_MODE_PDOWN) || (m == spc_pkg::SPC_MODE_PSAVE) ||
               (m == spc_pkg::SPC_MODE_STBY);
    endfunction

    // Deep modes stop both the I/O and the converter clock.
    function automatic logic mode_deep(input logic [2:0] m);
        return (m == spc_pkg::SPC_MODE_PDOWN) || (m == spc_pkg::SPC_MODE_PSAVE) ||
               (m == spc_pkg::SPC_MODE_STBY);
    endfunction

    function automatic spc_pkg::spc_state_t rst_state();
        spc_pkg::spc_state_t s;
        s = '0;
        s.sleep_ctl = `SPC_SLEEP_RST;
        s.gating = `SPC_GATING_RST;
        s.fsm = spc_pkg::SPC_ST_ACTIVE;
        s.clk = '1;
        s.cmp_en = 1'b1;
        s.cmp_mux_ok = 1'b1;
        s.port_buf = 8'hff;
        s.conv_buf = 8'hff;
        s.cmp_buf = 2'h3;
        return s;
    endfunction

    // ------------------------------------------------------------------------
    // Bus front end and pin synchronisers
    // ------------------------------------------------------------------------

    spc_pkg::spc_req_t req;
    spc_pkg::spc_state_t q;
    spc_pkg::spc_state_t d;
    logic [7:0] rdata;
    logic [7:0] pins_s;
    logic [2:0] fuse_bod_s;
    logic fuse_dbg_s;
    logic fuse_jtag_s;
    logic wdt_s;
    logic tap_shift_s;
    logic tdo_s;

    spc_wb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .rdata_i(rdata),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .req_o(req)
    );

    spc_sync #(
        .W(8)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({brownout_level_fuses_i, debug_enable_fuse_i, jtag_enable_fuse_i, wdt_enable_i,
                  tap_shift_i, tdo_data_i}),
        .sync_o(pins_s)
    );

    assign fuse_bod_s = pins_s[7:5];
    assign fuse_dbg_s = pins_s[4];
    assign fuse_jtag_s = pins_s[3];
    assign wdt_s = pins_s[2];
    assign tap_shift_s = pins_s[1];
    assign tdo_s = pins_s[0];

    // ------------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------------

    always_comb begin
        if (req.addr == `SPC_OFF_SLEEP_CTL) begin
            rdata = q.sleep_ctl;
        end else if (req.addr == `SPC_OFF_GATING) begin
            rdata = {3'h0, q.gating[4:0]};
        end else if (req.addr == `SPC_OFF_CORE_CTL) begin
            rdata = {q.jtag_disable_bit, 7'h00};
        end else if (req.addr == `SPC_OFF_IN_DIS0) begin
            rdata = q.in_dis0;
        end else if (req.addr == `SPC_OFF_IN_DIS1) begin
            rdata = {6'h00, q.in_dis1};
        end else if (req.addr == `SPC_OFF_ANALOG) begin
            rdata = {5'h00, q.analog};
        end else if (req.addr == `SPC_OFF_STATUS) begin
            rdata = {q.fsm, q.mode, q.conv_ext, q.vref_en, q.jtag_en};
        end else begin
            rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    logic sleeping;
    logic keep_osc;
    logic conv_on;
    logic cmp_bg;
    logic cmp_off;

    always_comb begin
        d = q;
        sleeping = 1'b0;
        keep_osc = 1'b0;
        conv_on = 1'b0;
        cmp_bg = 1'b0;
        cmp_off = 1'b0;

        // Register writes.
        if (req.wr) begin
            if (req.addr == `SPC_OFF_SLEEP_CTL) begin
                d.sleep_ctl = req.wdata & `SPC_SLEEP_MASK;
            end else if (req.addr == `SPC_OFF_GATING) begin
                d.gating = req.wdata & `SPC_GATING_MASK;
            end else if (req.addr == `SPC_OFF_CORE_CTL) begin
                d.jtag_disable_bit = req.wdata[`SPC_JTD_BIT];
            end else if (req.addr == `SPC_OFF_IN_DIS0) begin
                d.in_dis0 = req.wdata;
            end else if (req.addr == `SPC_OFF_IN_DIS1) begin
                d.in_dis1 = req.wdata[1:0];
            end else if (req.addr == `SPC_OFF_ANALOG) begin
                d.analog = req.wdata[2:0];
            end
        end

        // Sleep sequencer.
        case (q.fsm)
            spc_pkg::SPC_ST_ACTIVE: begin
                if (sleep_instr_i && q.sleep_ctl[`SPC_SE_BIT] &&
                    mode_valid(q.sleep_ctl[`SPC_SM_LSB +: 3])) begin
                    d.fsm = spc_pkg::SPC_ST_SLEEP;
                    d.mode = q.sleep_ctl[`SPC_SM_LSB +: 3];
                end
            end
            spc_pkg::SPC_ST_SLEEP: begin
                if (wake_irq_i) begin
                    d.fsm = spc_pkg::SPC_ST_WAKE;
                    if (q.mode == spc_pkg::SPC_MODE_STBY) begin
                        d.cnt = `SPC_STBY_WAKE_CYC - 8'h01;
                    end else if (mode_deep(q.mode)) begin
                        d.cnt = DEEP_WAKE_CYC - 8'h01;
                    end else begin
                        d.cnt = 8'h00;
                    end
                end
            end
            spc_pkg::SPC_ST_WAKE: begin
                if (q.cnt == 8'h00) begin
                    d.fsm = spc_pkg::SPC_ST_HALT;
                    d.cnt = `SPC_WAKE_HALT_CYC - 8'h01;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            spc_pkg::SPC_ST_HALT: begin
                if (q.cnt == 8'h00) begin
                    d.fsm = spc_pkg::SPC_ST_ACTIVE;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            default: begin
                d.fsm = spc_pkg::SPC_ST_ACTIVE;
            end
        endcase

        sleeping = (d.fsm == spc_pkg::SPC_ST_SLEEP);

        // JTAG and debug clock keep-alive.
        d.jtag_en = fuse_jtag_s && !d.jtag_disable_bit;
        keep_osc = fuse_dbg_s && d.jtag_en;
        d.tdo = tdo_s;
        d.tdo_oe = d.jtag_en && tap_shift_s;

        // Clock domains.
        d.clk.cpu_clk = (d.fsm == spc_pkg::SPC_ST_ACTIVE);
        d.clk.flash_clk = (d.fsm == spc_pkg::SPC_ST_ACTIVE);
        d.clk.io_clk = !(sleeping && (d.mode != spc_pkg::SPC_MODE_IDLE));
        d.clk.conv_clk = !(sleeping && mode_deep(d.mode)) && !d.gating[`SPC_GATE_CONV];
        d.clk.osc_run = !(sleeping && ((d.mode == spc_pkg::SPC_MODE_PDOWN) ||
                                       (d.mode == spc_pkg::SPC_MODE_PSAVE))) || keep_osc;
        d.clk.lcd_clk = !d.gating[`SPC_GATE_LCD];
        d.clk.tim16_clk = d.clk.io_clk && !d.gating[`SPC_GATE_TIM16];
        d.clk.spi_clk = d.clk.io_clk && !d.gating[`SPC_GATE_SPI];
        d.clk.usart_clk = d.clk.io_clk && !d.gating[`SPC_GATE_USART];
        d.reg_block = d.gating[4:0];
        d.cpu_halt = (d.fsm != spc_pkg::SPC_ST_ACTIVE);

        // Converter, comparator and reference.
        conv_on = d.analog[`SPC_ANA_CONV_EN] && !d.gating[`SPC_GATE_CONV];
        d.conv_en = conv_on;
        d.conv_en_prev = conv_on;
        if (conv_on && !q.conv_en_prev) begin
            d.conv_ext = 1'b1;
        end else if (conv_start_i) begin
            d.conv_ext = 1'b0;
        end
        cmp_off = d.analog[`SPC_ANA_CMP_DIS];
        cmp_bg = d.analog[`SPC_ANA_CMP_BG] && !cmp_off;
        d.cmp_en = !cmp_off && (!sleeping || !mode_deep(d.mode));
        d.cmp_mux_ok = !d.gating[`SPC_GATE_CONV];
        d.bod_en = (fuse_bod_s != `SPC_BOD_OFF_CODE);
        d.vref_en = d.bod_en || cmp_bg || conv_on;
        d.wdt_en = wdt_s;

        // Digital input buffers.
        d.port_buf = (sleeping && mode_deep(d.mode)) ? wake_pin_mask_i : 8'hff;
        d.conv_buf = (sleeping && mode_deep(d.mode)) ? 8'h00 : ~d.in_dis0;
        d.cmp_buf = (sleeping && mode_deep(d.mode)) ? 2'h0 : ~d.in_dis1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= rst_state();
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign cpu_clk_en_o = q.clk.cpu_clk;
    assign flash_clk_en_o = q.clk.flash_clk;
    assign io_clk_en_o = q.clk.io_clk;
    assign conv_clk_en_o = q.clk.conv_clk;
    assign osc_run_o = q.clk.osc_run;
    assign lcd_clk_en_o = q.clk.lcd_clk;
    assign tim16_clk_en_o = q.clk.tim16_clk;
    assign spi_clk_en_o = q.clk.spi_clk;
    assign usart_clk_en_o = q.clk.usart_clk;
    assign conv_en_o = q.conv_en;
    assign conv_extended_o = q.conv_ext;
    assign cmp_en_o = q.cmp_en;
    assign cmp_mux_ok_o = q.cmp_mux_ok;
    assign vref_en_o = q.vref_en;
    assign bod_en_o = q.bod_en;
    assign wdt_en_o = q.wdt_en;
    assign jtag_en_o = q.jtag_en;
    assign tdo_o = q.tdo;
    assign tdo_oe_o = q.tdo_oe;
    assign cpu_halt_o = q.cpu_halt;
    assign port_buf_en_o = q.port_buf;
    assign conv_buf_en_o = q.conv_buf;
    assign cmp_buf_en_o = q.cmp_buf;
    assign reg_block_o = q.reg_block;

endmodule

`default_nettype wire

//--- hw/spc_cfg.svh
// Offsets, field positions, reset values and timing counts of the sleep and power control block.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SPC_OFF_SLEEP_CTL 8'h00
`define SPC_OFF_GATING 8'h04
`define SPC_OFF_CORE_CTL 8'h08
`define SPC_OFF_IN_DIS0 8'h0c
`define SPC_OFF_IN_DIS1 8'h10
`define SPC_OFF_ANALOG 8'h14
`define SPC_OFF_STATUS 8'h18

// ----------------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------------
`define SPC_SE_BIT 0
`define SPC_SM_LSB 1
`define SPC_SLEEP_MASK 8'h0f
`define SPC_GATING_MASK 8'h1f
`define SPC_GATE_CONV 0
`define SPC_GATE_USART 1
`define SPC_GATE_SPI 2
`define SPC_GATE_TIM16 3
`define SPC_GATE_LCD 4
`define SPC_JTD_BIT 7
`define SPC_ANA_CONV_EN 0
`define SPC_ANA_CMP_DIS 1
`define SPC_ANA_CMP_BG 2
`define SPC_BOD_OFF_CODE 3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPC_SLEEP_RST 8'h00
`define SPC_GATING_RST 8'h00

// ----------------------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------------------
`define SPC_WAKE_HALT_CYC 8'h04
`define SPC_STBY_WAKE_CYC 8'h06
`define SPC_DEEP_WAKE_CYC 8'h10

`endif

//--- hw/spc_pkg.sv
// Types shared by the sleep and power control block.
`default_nettype none

package spc_pkg;

    typedef enum logic [1:0] {
        SPC_ST_ACTIVE = 2'h0,
        SPC_ST_SLEEP = 2'h1,
        SPC_ST_WAKE = 2'h3,
        SPC_ST_HALT = 2'h2
    } spc_fsm_t;

    typedef enum logic [2:0] {
        SPC_MODE_IDLE = 3'h0,
        SPC_MODE_NOISE = 3'h1,
        SPC_MODE_PDOWN = 3'h2,
        SPC_MODE_PSAVE = 3'h3,
        SPC_MODE_STBY = 3'h6
    } spc_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spc_req_t;

    typedef struct packed {
        logic cpu_clk;
        logic flash_clk;
        logic io_clk;
        logic conv_clk;
        logic osc_run;
        logic lcd_clk;
        logic tim16_clk;
        logic spi_clk;
        logic usart_clk;
    } spc_clk_t;

    typedef struct packed {
        logic [7:0] sleep_ctl;
        logic [7:0] gating;
        logic jtag_disable_bit;
        logic [7:0] in_dis0;
        logic [1:0] in_dis1;
        logic [2:0] analog;
        spc_fsm_t fsm;
        logic [2:0] mode;
        logic [7:0] cnt;
        logic conv_en_prev;
        spc_clk_t clk;
        logic conv_en;
        logic conv_ext;
        logic cmp_en;
        logic cmp_mux_ok;
        logic vref_en;
        logic bod_en;
        logic wdt_en;
        logic jtag_en;
        logic tdo;
        logic tdo_oe;
        logic cpu_halt;
        logic [7:0] port_buf;
        logic [7:0] conv_buf;
        logic [1:0] cmp_buf;
        logic [4:0] reg_block;
    } spc_state_t;

endpackage

`default_nettype wire

//--- hw/spc_sync.sv
// Three-stage input synchroniser that updates once the last two stages agree.
`timescale 1ns/1ns
`default_nettype none

module spc_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_o <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- hw/spc_wb_slave.sv
// Classic Wishbone slave front end with one wait state and registered read data.
`timescale 1ns/1ns
`default_nettype none

module spc_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [7:0] rdata_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output spc_pkg::spc_req_t req_o
);

    logic req_live;

    assign req_live = wb_cyc_i && wb_stb_i;

    // A write lands on the edge at which the master samples ack high.
    always_comb begin
        req_o.wr = req_live && wb_ack_o && wb_we_i && wb_sel_i[0];
        req_o.rd = req_live && !wb_ack_o && !wb_we_i;
        req_o.addr = wb_adr_i;
        req_o.wdata = wb_dat_i[7:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_live && !wb_ack_o;
            if (req_o.rd) begin
                wb_dat_o <= {24'h00_0000, rdata_i};
            end
        end
    end

endmodule

`default_nettype wire

//--- testbench/spc_top_props.sv
// Concurrent checks on the ports of the sleep and power control block.
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module spc_top_props #(
    parameter logic [7:0] DEEP_WAKE_CYC = 8'h10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sleep_instr_i,
    input wire logic [7:0] wake_pin_mask_i,
    input wire logic cpu_clk_en_o,
    input wire logic flash_clk_en_o,
    input wire logic io_clk_en_o,
    input wire logic conv_clk_en_o,
    input wire logic osc_run_o,
    input wire logic lcd_clk_en_o,
    input wire logic conv_en_o,
    input wire logic cmp_en_o,
    input wire logic cmp_mux_ok_o,
    input wire logic vref_en_o,
    input wire logic bod_en_o,
    input wire logic wdt_en_o,
    input wire logic jtag_en_o,
    input wire logic tdo_oe_o,
    input wire logic cpu_halt_o,
    input wire logic [7:0] port_buf_en_o,
    input wire logic [7:0] conv_buf_en_o,
    input wire logic [4:0] reg_block_o
);
    // A deep wake runs the start-up count, then three of the four halt cycles precede the last halted one.
    localparam int DW = int'(DEEP_WAKE_CYC) + 3;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_halt_then_run;
        !cpu_clk_en_o ##1 cpu_clk_en_o;
    endsequence
    sequence s_noise_wake;
        $rose(io_clk_en_o) && $past(conv_clk_en_o);
    endsequence

    property p_enter; $rose(cpu_halt_o) |-> $past(sleep_instr_i); endproperty
    a_enter: assert property (p_enter) else $error("sleep entered without instruction");
    property p_noise_wake; s_noise_wake |-> ##4 s_halt_then_run; endproperty
    a_noise_wake: assert property (p_noise_wake) else $error("noise wake halt length");
    property p_deep_wake; $rose(osc_run_o) && cpu_halt_o |-> ##DW s_halt_then_run; endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("deep wake length");
    property p_cpu_clk; cpu_clk_en_o == flash_clk_en_o && cpu_clk_en_o == !cpu_halt_o; endproperty
    a_cpu_clk: assert property (p_cpu_clk) else $error("core clocks disagree with halt");
    property p_deep_cmp; cpu_halt_o && !osc_run_o |-> !cmp_en_o && !conv_clk_en_o; endproperty
    a_deep_cmp: assert property (p_deep_cmp) else $error("comparator on in deep sleep");
    property p_buf; !io_clk_en_o && !conv_clk_en_o |-> (port_buf_en_o & ~wake_pin_mask_i) == 8'h00 &&
        conv_buf_en_o == 8'h00; endproperty
    a_buf: assert property (p_buf) else $error("input buffers on with clocks stopped");
    property p_keep; cpu_halt_o |-> $stable(wdt_en_o) && $stable(bod_en_o); endproperty
    a_keep: assert property (p_keep) else $error("watchdog or brown-out changed in sleep");
    property p_vref; bod_en_o || conv_en_o |-> vref_en_o; endproperty
    a_vref: assert property (p_vref) else $error("reference off while needed");
    property p_conv_gate; reg_block_o[0] |-> !conv_en_o && !cmp_mux_ok_o && !conv_clk_en_o; endproperty
    a_conv_gate: assert property (p_conv_gate) else $error("converter active while gated");
    property p_lcd; lcd_clk_en_o != reg_block_o[4]; endproperty
    a_lcd: assert property (p_lcd) else $error("display clock disagrees with gating");
    property p_tdo; tdo_oe_o |-> jtag_en_o; endproperty
    a_tdo: assert property (p_tdo) else $error("test data driven with jtag off");
    property p_gread; wb_ack_o && !wb_we_i && wb_adr_i == `SPC_OFF_GATING |-> wb_dat_o[31:5] == 27'h0; endproperty
    a_gread: assert property (p_gread) else $error("gating reserved bits read nonzero");
endmodule

bind spc_top spc_top_props #(.DEEP_WAKE_CYC(DEEP_WAKE_CYC)) u_props (
    .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sleep_instr_i, .wake_pin_mask_i,
    .cpu_clk_en_o, .flash_clk_en_o, .io_clk_en_o, .conv_clk_en_o, .osc_run_o, .lcd_clk_en_o, .conv_en_o,
    .cmp_en_o, .cmp_mux_ok_o, .vref_en_o, .bod_en_o, .wdt_en_o, .jtag_en_o, .tdo_oe_o, .cpu_halt_o,
    .port_buf_en_o, .conv_buf_en_o, .reg_block_o
);

`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the sleep and power control block.
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module testbench;
    localparam logic [7:0] DW = 8'h02;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic sleep_instr_i = 1'b0, wake_irq_i = 1'b0, conv_start_i = 1'b0, debug_enable_fuse_i = 1'b0;
    logic jtag_enable_fuse_i = 1'b1, wdt_enable_i = 1'b1, tap_shift_i = 1'b0, tdo_data_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, wake_pin_mask_i = 8'h0f;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic [2:0] brownout_level_fuses_i = 3'h2;
    logic wb_ack_o, cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, conv_clk_en_o, osc_run_o, lcd_clk_en_o;
    logic tim16_clk_en_o, spi_clk_en_o, usart_clk_en_o, conv_en_o, conv_extended_o, cmp_en_o, cmp_mux_ok_o;
    logic vref_en_o, bod_en_o, wdt_en_o, jtag_en_o, tdo_o, tdo_oe_o, cpu_halt_o;
    logic [31:0] wb_dat_o, rd;
    logic [7:0] port_buf_en_o, conv_buf_en_o;
    logic [1:0] cmp_buf_en_o;
    logic [4:0] reg_block_o;
    int fails = 0;
    int comparisons = 0;
    // Rows: mode code, expected {halt, io, conv clk, osc, cmp, conv en, brown-out, watchdog}, wake cycles.
    logic [18:0] rows [8] = '{{3'h0, 8'hff, 8'h01}, {3'h1, 8'hbf, 8'h01}, {3'h2, 8'h87, DW}, {3'h3, 8'h87, DW},
        {3'h6, 8'h97, 8'h06}, {3'h4, 8'h7f, 8'h00}, {3'h5, 8'h7f, 8'h00}, {3'h7, 8'h7f, 8'h00}};
    // Analog control value beside expected {reference, brown-out, comparator}.
    logic [5:0] ana [4] = '{6'h01, 6'h25, 6'h30, 6'h0d};

    spc_top #(.DEEP_WAKE_CYC(DW)) u_dut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .sleep_instr_i, .wake_irq_i, .conv_start_i, .brownout_level_fuses_i, .debug_enable_fuse_i,
        .jtag_enable_fuse_i, .wdt_enable_i, .tap_shift_i, .tdo_data_i, .wake_pin_mask_i, .cpu_clk_en_o,
        .flash_clk_en_o, .io_clk_en_o, .conv_clk_en_o, .osc_run_o, .lcd_clk_en_o, .tim16_clk_en_o,
        .spi_clk_en_o, .usart_clk_en_o, .conv_en_o, .conv_extended_o, .cmp_en_o, .cmp_mux_ok_o, .vref_en_o,
        .bod_en_o, .wdt_en_o, .jtag_en_o, .tdo_o, .tdo_oe_o, .cpu_halt_o, .port_buf_en_o, .conv_buf_en_o,
        .cmp_buf_en_o, .reg_block_o
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("bus ack", 32'h1, {31'h0, wb_ack_o});
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // Requests a sleep, checks the clock picture, then, when nw is nonzero, wakes the core and counts cycles until it runs.
    task automatic nap(input logic se, input logic [2:0] m, input logic [7:0] e, input logic [7:0] nw);
        int n;
        wb(1'b1, `SPC_OFF_SLEEP_CTL, {4'h0, m, se}, rd);
        sleep_instr_i <= 1'b1;
        @(posedge clk_i);
        sleep_instr_i <= 1'b0;
        @(posedge clk_i);
        chk("sleep state", {24'h0, e}, {24'h0, cpu_halt_o, io_clk_en_o, conv_clk_en_o, osc_run_o, cmp_en_o,
            conv_en_o, bod_en_o, wdt_en_o});
        if (nw != 8'h00) begin
            wake_irq_i <= 1'b1;
            @(posedge clk_i);
            wake_irq_i <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (cpu_clk_en_o !== 1'b1 && n < 100);
            // The core runs nw plus four cycles after the wake edge; the loop sees it one edge later.
            chk("wake cycles", {24'h0, nw} + 32'h5, n);
        end
        wb(1'b1, `SPC_OFF_SLEEP_CTL, 8'h00, rd);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        #80000;
        fails++;
        report_and_stop();
    end

    initial begin
        logic [4:0] g;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, `SPC_OFF_SLEEP_CTL, 8'h00, rd);
        chk("sleep_control reset", 32'h0, rd);
        wb(1'b0, `SPC_OFF_GATING, 8'h00, rd);
        chk("gating reset", 32'h0, rd);
        wb(1'b0, 8'h1c, 8'h00, rd);
        chk("unmapped read", 32'h0, rd);
        wb(1'b1, `SPC_OFF_ANALOG, 8'h01, rd);
        foreach (rows[i]) nap(1'b1, rows[i][18:16], rows[i][15:8], rows[i][7:0]);
        nap(1'b0, 3'h2, 8'h7f, 8'h00);
        debug_enable_fuse_i <= 1'b1;
        tap_shift_i <= 1'b1;
        tdo_data_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("tap shifting", 32'h7, {29'h0, tdo_oe_o, tdo_o, jtag_en_o});
        tap_shift_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("tap idle", 32'h3, {29'h0, tdo_oe_o, tdo_o, jtag_en_o});
        nap(1'b1, 3'h2, 8'h97, DW);
        wb(1'b1, `SPC_OFF_CORE_CTL, 8'h80, rd);
        chk("jtag off", 32'h0, {31'h0, jtag_en_o});
        nap(1'b1, 3'h2, 8'h87, DW);
        brownout_level_fuses_i <= 3'h7;
        repeat (8) @(posedge clk_i);
        foreach (ana[i]) begin
            wb(1'b1, `SPC_OFF_ANALOG, {5'h0, ana[i][5:3]}, rd);
            chk("reference", {29'h0, ana[i][2:0]}, {29'h0, vref_en_o, bod_en_o, cmp_en_o});
        end
        conv_start_i <= 1'b1;
        @(posedge clk_i);
        conv_start_i <= 1'b0;
        @(posedge clk_i);
        chk("extended cleared", 32'h0, {31'h0, conv_extended_o});
        for (int i = 0; i < 5; i++) begin
            g = 5'h01 << i;
            wb(1'b1, `SPC_OFF_GATING, {3'h0, g}, rd);
            chk("gating", {20'h0, 5'h1f ^ g, g, {2{i != 0}}}, {20'h0, lcd_clk_en_o, tim16_clk_en_o,
                spi_clk_en_o, usart_clk_en_o, conv_clk_en_o, reg_block_o, conv_en_o, cmp_mux_ok_o});
        end
        chk("extended after restart", 32'h1, {31'h0, conv_extended_o});
        wb(1'b1, `SPC_OFF_GATING, 8'hff, rd);
        wb(1'b0, `SPC_OFF_GATING, 8'h00, rd);
        chk("gating readback", 32'h1f, rd);
        wb(1'b1, `SPC_OFF_IN_DIS0, 8'ha5, rd);
        wb(1'b1, `SPC_OFF_IN_DIS1, 8'h02, rd);
        chk("input buffers", 32'h169, {22'h0, conv_buf_en_o, cmp_buf_en_o});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, `SPC_OFF_GATING, 8'h00, rd);
        chk("gating after reset", 32'h0, rd);
        report_and_stop();
    end
endmodule

`default_nettype wire
